// ===== core/misc_status_register_bank.sv
`timescale 1ns/100ps

// Overview of operation
// - read-only misc status at offset 4h, resets zero, bits 23..13 read zero
// - bit 12 shows converter self-diagnostic error
// - bit 11 shows abnormal current sink on input channel 3
// - bit 10 shows abnormal current sink on input channel 2
// - bit 9 shows abnormal current source on input channel 1
// - bit 8 shows abnormal current source on input channel 0
// - bits 7..6 give supply level against band-1 lower and upper thresholds
// - bits 5..4 give supply level against band-0 lower and upper thresholds
// - bit 3 shows supply below under-voltage threshold
// - bit 2 shows supply above over-voltage threshold
// - bit 1 shows junction temperature above warning threshold
// - bit 0 shows junction temperature above shutdown threshold
// - read-only comparator result per input at offset 5h, resets zero
module misc_status_register_bank (
  input  wire logic                                         clock,       // 10 MHz clock
  input  wire logic                                         arst_n,      // async reset
  input  wire status_bank_pkg::cond_s                       cond_async,  // live conditions
  input  wire logic [status_bank_pkg::NUM_IN-1:0]           comp_async,  // comparator per input
  input  wire logic [status_bank_pkg::VS_W-1:0]             supply_code, // supply ADC result
  input  wire status_bank_pkg::band_thr_s                   band_thr,    // band thresholds
  input  wire status_bank_pkg::rd_req_s                     rd_req,      // register read request
  output status_bank_pkg::rd_rsp_s                          rd_rsp_q,    // register read answer
  output logic [status_bank_pkg::DATA_W-1:0]                misc_status_q // live misc status
);

  localparam int unsigned COND_W = $bits(status_bank_pkg::cond_s);

  // synchronised inputs
  status_bank_pkg::cond_s                  cond_sync;
  logic [COND_W-1:0]                       cond_sync_bits;
  logic [status_bank_pkg::NUM_IN-1:0]      comp_sync;

  // band encoders
  status_bank_pkg::band_e                  band1_d;
  status_bank_pkg::band_e                  band0_d;

  // register contents
  logic [status_bank_pkg::DATA_W-1:0]      misc_status_d;
  logic [status_bank_pkg::DATA_W-1:0]      comp_status_q;
  logic [status_bank_pkg::DATA_W-1:0]      rd_data_d;

  // --------------------------------------------------------------------------
  // crossing of the analog / diagnostic levels into the clock domain
  // --------------------------------------------------------------------------
  level_sync #(
    .WIDTH (COND_W)
  ) u_cond_sync (
    .clock   (clock),
    .arst_n  (arst_n),
    .async_i (cond_async),
    .sync_o  (cond_sync_bits)
  );

  assign cond_sync = status_bank_pkg::cond_s'(cond_sync_bits);

  level_sync #(
    .WIDTH (status_bank_pkg::NUM_IN)
  ) u_comp_sync (
    .clock   (clock),
    .arst_n  (arst_n),
    .async_i (comp_async),
    .sync_o  (comp_sync)
  );

  // --------------------------------------------------------------------------
  // supply band classification
  // upper threshold is tested first, so a lower threshold set above the upper
  // one can only shrink the middle band, never yield the unused code
  // --------------------------------------------------------------------------
  function automatic status_bank_pkg::band_e classify_band(
    input logic [status_bank_pkg::VS_W-1:0] level,
    input logic [status_bank_pkg::VS_W-1:0] lower,
    input logic [status_bank_pkg::VS_W-1:0] upper
  );
    status_bank_pkg::band_e code;
    code = status_bank_pkg::BAND_BELOW_LOWER;
    if (level >= upper) begin
      code = status_bank_pkg::BAND_ABOVE_UPPER;
    end else if (level >= lower) begin
      code = status_bank_pkg::BAND_BETWEEN;
    end
    return code;
  endfunction

  always_comb begin
    band1_d = classify_band(supply_code,
                            band_thr.band1_lower_threshold,
                            band_thr.band1_upper_threshold);
    band0_d = classify_band(supply_code,
                            band_thr.band0_lower_threshold,
                            band_thr.band0_upper_threshold);
  end

  // --------------------------------------------------------------------------
  // misc status word assembly
  // --------------------------------------------------------------------------
  always_comb begin
    misc_status_d = status_bank_pkg::MISC_STATUS_RESET;
    misc_status_d[status_bank_pkg::RSVD_HI_POS:status_bank_pkg::RSVD_LO_POS] = '0;
    misc_status_d[status_bank_pkg::ADC_FAULT_POS] =
      cond_sync.adc_selftest_fault;
    misc_status_d[status_bank_pkg::SINK_CH3_POS] =
      cond_sync.sink_ch3_fault;
    misc_status_d[status_bank_pkg::SINK_CH2_POS] =
      cond_sync.sink_ch2_fault;
    misc_status_d[status_bank_pkg::SOURCE_CH1_POS] =
      cond_sync.source_ch1_fault;
    misc_status_d[status_bank_pkg::SOURCE_CH0_POS] =
      cond_sync.source_ch0_fault;
    misc_status_d[status_bank_pkg::BAND1_HI_POS:status_bank_pkg::BAND1_LO_POS] =
      band1_d;
    misc_status_d[status_bank_pkg::BAND0_HI_POS:status_bank_pkg::BAND0_LO_POS] =
      band0_d;
    misc_status_d[status_bank_pkg::UNDERVOLT_POS] =
      cond_sync.undervoltage_live;
    misc_status_d[status_bank_pkg::OVERVOLT_POS] =
      cond_sync.overvoltage_live;
    misc_status_d[status_bank_pkg::THERM_WARN_POS] =
      cond_sync.thermal_warning_live;
    misc_status_d[status_bank_pkg::THERM_SHUT_POS] =
      cond_sync.thermal_shutdown_live;
  end

  // misc status follows the present conditions every cycle, no sticky bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      misc_status_q <= status_bank_pkg::MISC_STATUS_RESET;
    end else begin
      misc_status_q <= misc_status_d;
    end
  end

  // comparator status: one bit per input, above threshold reads one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      comp_status_q <= status_bank_pkg::COMP_STATUS_RESET;
    end else begin
      comp_status_q <= comp_sync;
    end
  end

  // --------------------------------------------------------------------------
  // read port: both registers are read-only; a read only samples them
  // --------------------------------------------------------------------------
  always_comb begin
    if (rd_req.addr == status_bank_pkg::MISC_STATUS_OFFSET) begin
      rd_data_d = misc_status_q;
    end else if (rd_req.addr == status_bank_pkg::COMP_STATUS_OFFSET) begin
      rd_data_d = comp_status_q;
    end else begin
      rd_data_d = status_bank_pkg::UNMAPPED_READ;
    end
  end

  // valid and data share one process so the answer struct has a single driver
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_rsp_q.valid <= 1'b0;
      rd_rsp_q.data  <= status_bank_pkg::UNMAPPED_READ;
    end else begin
      rd_rsp_q.valid <= rd_req.en;
      if (rd_req.en) begin
        rd_rsp_q.data <= rd_data_d;
      end
    end
  end

endmodule // misc_status_register_bank

// ===== core/status_bank_pkg.sv
package status_bank_pkg;

  // register file geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned VS_W   = 10;
  localparam int unsigned NUM_IN = 24;

  // register offsets (word index on the serial register port)
  localparam logic [ADDR_W-1:0] MISC_STATUS_OFFSET = 6'h04;
  localparam logic [ADDR_W-1:0] COMP_STATUS_OFFSET = 6'h05;

  // reset values
  localparam logic [DATA_W-1:0] MISC_STATUS_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] COMP_STATUS_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ     = 24'h000000;

  // misc status field positions
  localparam int unsigned RSVD_HI_POS       = 23;
  localparam int unsigned RSVD_LO_POS       = 13;
  localparam int unsigned ADC_FAULT_POS     = 12;
  localparam int unsigned SINK_CH3_POS      = 11;
  localparam int unsigned SINK_CH2_POS      = 10;
  localparam int unsigned SOURCE_CH1_POS    = 9;
  localparam int unsigned SOURCE_CH0_POS    = 8;
  localparam int unsigned BAND1_HI_POS      = 7;
  localparam int unsigned BAND1_LO_POS      = 6;
  localparam int unsigned BAND0_HI_POS      = 5;
  localparam int unsigned BAND0_LO_POS      = 4;
  localparam int unsigned UNDERVOLT_POS     = 3;
  localparam int unsigned OVERVOLT_POS      = 2;
  localparam int unsigned THERM_WARN_POS    = 1;
  localparam int unsigned THERM_SHUT_POS    = 0;

  // number of synchroniser stages on live condition inputs
  localparam int unsigned SYNC_STAGES = 2;

  // supply band codes; code 2'h3 is never produced
  typedef enum logic [1:0] {
    BAND_BELOW_LOWER = 2'b00,
    BAND_BETWEEN     = 2'b01,
    BAND_ABOVE_UPPER = 2'b10
  } band_e;

  // live single-bit conditions from analog/diagnostic blocks
  typedef struct packed {
    logic adc_selftest_fault;
    logic sink_ch3_fault;
    logic sink_ch2_fault;
    logic source_ch1_fault;
    logic source_ch0_fault;
    logic undervoltage_live;
    logic overvoltage_live;
    logic thermal_warning_live;
    logic thermal_shutdown_live;
  } cond_s;

  // supply band thresholds, from configuration logic on this clock
  typedef struct packed {
    logic [VS_W-1:0] band1_lower_threshold;
    logic [VS_W-1:0] band1_upper_threshold;
    logic [VS_W-1:0] band0_lower_threshold;
    logic [VS_W-1:0] band0_upper_threshold;
  } band_thr_s;

  // register read request and answer
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
  } rd_req_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } rd_rsp_s;

endpackage

// ===== core/level_sync.sv
`timescale 1ns/100ps

// two-stage synchroniser for a bundle of independent levels
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,   // system clock
  input  wire logic             arst_n,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_i, // levels from another domain
  output logic      [WIDTH-1:0] sync_o   // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // level_sync

// ===== test/status_bank_props.sv
`timescale 1ns/100ps
module status_bank_props (
  input wire logic                      clock,         // clock
  input wire logic                      arst_n,        // reset
  input wire status_bank_pkg::cond_s    cond_async,    // live conditions
  input wire logic [23:0]               comp_async,    // comparator levels
  input wire logic [9:0]                supply_code,   // supply code
  input wire status_bank_pkg::band_thr_s band_thr,     // thresholds
  input wire status_bank_pkg::rd_req_s  rd_req,        // read request
  input wire status_bank_pkg::rd_rsp_s  rd_rsp_q,      // read answer
  input wire logic [23:0]               misc_status_q  // live status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [1:0] b1_d;
  logic [1:0] b0_d;
  logic       ok3;
  assign b1_d = supply_code >= band_thr[29:20] ? 2'h2 : (supply_code >= band_thr[39:30]);
  assign b0_d = supply_code >= band_thr[9:0] ? 2'h2 : (supply_code >= band_thr[19:10]);
  assign ok3 = rd_req.en && rd_req.addr == 6'h05;
  rsvd_zero_a: assert property (misc_status_q[23:13] == 11'h000)
    else $error("reserved bits set");
  band_legal_a: assert property (
    misc_status_q[7:6] != 2'h3 && misc_status_q[5:4] != 2'h3) else $error("band code 3");
  read_answer_a: assert property (rd_req.en |=> rd_rsp_q.valid)
    else $error("no answer");
  no_spurious_a: assert property (!rd_req.en |=> !rd_rsp_q.valid)
    else $error("spurious answer");
  data_hold_a: assert property (!rd_req.en |=> $stable(rd_rsp_q.data))
    else $error("data moved");
  misc_read_a: assert property (rd_req.en && rd_req.addr == 6'h04 |=>
    rd_rsp_q.data == $past(misc_status_q)) else $error("misc read wrong");
  unmapped_zero_a: assert property (rd_req.en && rd_req.addr != 6'h04 && !ok3 |=>
    rd_rsp_q.data == 24'h000000) else $error("unmapped not zero");
  band_track_a: assert property ($past(arst_n) |->
    misc_status_q[7:4] == {$past(b1_d), $past(b0_d)}) else $error("band wrong");
  cond_track_a: assert property (
    $past(arst_n, 3) && $past(arst_n, 2) && $past(arst_n) |->
    {misc_status_q[12:8], misc_status_q[3:0]} == $past(cond_async, 3)) else $error("cond wrong");
  comp_read_a: assert property (
    ok3 && $past(arst_n, 3) && $past(arst_n, 2) && $past(arst_n) |=>
    rd_rsp_q.data == $past(comp_async, 4)) else $error("comp read wrong");
  cover property (rd_req.en ##1 rd_req.en);
  cover property ($rose(misc_status_q[2]));
  cover property (misc_status_q[7:6] == 2'h2);
endmodule // status_bank_props

bind misc_status_register_bank status_bank_props i_status_bank_props (.clock, .arst_n,
  .cond_async, .comp_async, .supply_code, .band_thr, .rd_req, .rd_rsp_q, .misc_status_q);

// ===== test/mcu_reader.sv
`timescale 1ns/100ps
module mcu_reader (
  input  wire logic                     clock,   // clock
  input  wire logic                     arst_n,  // reset
  input  wire logic                     go,      // issue a read
  input  wire logic [5:0]               go_addr, // read address
  output status_bank_pkg::rd_req_s      rd_req   // read request
);
  // idle address is inverted so a stale address is never seen as valid
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_req <= '0;
    end else begin
      rd_req.en   <= go;
      rd_req.addr <= go ? go_addr : ~rd_req.addr;
    end
  end
endmodule // mcu_reader

// ===== test/misc_status_register_bank_tb_top.sv
`timescale 1ns/100ps
module misc_status_register_bank_tb_top;
  logic                       clock = 1'b0;
  logic                       arst_n = 1'b0;
  logic                       go = 1'b0;
  logic [5:0]                 go_addr = '0;
  status_bank_pkg::cond_s     cond_async = '0;
  logic [23:0]                comp_async = '0;
  logic [9:0]                 supply_code = '0;
  status_bank_pkg::band_thr_s band_thr = '0;
  status_bank_pkg::rd_req_s   rd_req;
  status_bank_pkg::rd_rsp_s   rd_rsp_q;
  logic [23:0]                misc_status_q;
  logic [39:0]                t;
  logic [25:0]                note;
  logic [25:0]                note_q[$];
  int                         bad_count = 0;
  int                         total_checks = 0;
  int                         cycles = 0;
  always #50 clock = ~clock;
  mcu_reader i_mcu_reader (.clock, .arst_n, .go, .go_addr, .rd_req);
  misc_status_register_bank i_misc_status_register_bank (.clock, .arst_n, .cond_async,
    .comp_async, .supply_code, .band_thr, .rd_req, .rd_rsp_q, .misc_status_q);
  function automatic logic [1:0] band(logic [9:0] s, logic [9:0] l, logic [9:0] u);
    return s >= u ? 2'h2 : (s >= l ? 2'h1 : 2'h0);
  endfunction
  function automatic logic [23:0] misc_exp();
    return {11'h000, cond_async[8:4], band(supply_code, band_thr[39:30], band_thr[29:20]),
            band(supply_code, band_thr[19:10], band_thr[9:0]), cond_async[3:0]};
  endfunction
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic read_reg(input logic [5:0] a, input logic [1:0] k, input logic [23:0] e);
    @(posedge clock);
    go <= 1'b1;
    go_addr <= a;
    note_q.push_back({k, e});
  endtask
  always @(posedge clock) begin
    if (rd_rsp_q.valid === 1'b1 && note_q.size() == 0) begin
      bad_count++;
      $display("[ERR] %0t: answer with no pending read", $time);
    end else if (rd_rsp_q.valid === 1'b1) begin
      note = note_q.pop_front();
      case (note[25:24])
        2'h0: check_word(rd_rsp_q.data, note[23:0]);
        2'h1: check_word(rd_rsp_q.data, note[23:0]);
        default: check_word(rd_rsp_q.data, note[23:0]);
      endcase
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h514dcd4d));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      t = 40'({$urandom, $urandom});
      band_thr <= t;
      cond_async <= 9'($urandom);
      comp_async <= 24'($urandom);
      supply_code <= (i % 3 == 0) ? t[29:20] : ((i % 3 == 1) ? t[9:0] : 10'($urandom));
      repeat (4) @(posedge clock);
      read_reg(6'h04, 2'h0, misc_exp());
      read_reg(6'h05, 2'h1, comp_async);
      read_reg(6'($urandom_range(6, 63)), 2'h2, 24'h000000);
      read_reg(6'(i % 4), 2'h2, 24'h000000);
      read_reg(6'h04, 2'h0, misc_exp());
      @(posedge clock) go <= 1'b0;
      if (i == 30) begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        check_word(misc_status_q, 24'h000000);
        check_word(rd_rsp_q.data, 24'h000000);
        arst_n <= 1'b1;
      end
    end
    repeat (5) @(posedge clock);
    complete_run();
  end
endmodule // misc_status_register_bank_tb_top
